// *** acl_match_pkg.sv ***
// Constants, field layouts and carrier types for the ingress classification and access-check logic.
// Assumes one core clock, registers reached over a plain strobe port, and parsed keys from the pipeline.
package acl_match_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_PORTS = 11;
    localparam int FS_ENTRIES = 4;
    localparam int AC_ENTRIES = 8;

    // ----------------------------------------------------------------
    // Register map (word addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] PORT_CFG_LAST = 8'h0A;
    localparam logic [7:0] COMMON_DEF_ADDR = 8'h10;
    localparam logic [7:0] STATUS_ADDR = 8'h11;
    localparam logic [3:0] FS_REGION = 4'h2;
    localparam logic [2:0] AC_REGION = 3'h2;

    // Port configuration word: tag, default class, first-lookup default action.
    localparam int PCFG_TAG_POS = 0;
    localparam int PCFG_QOS_POS = 8;
    localparam int PCFG_ACT_POS = 11;

    // First-stage entry words.
    localparam int FS_W_KEY = 0;
    localparam int FS_W_MASK = 1;
    localparam int FS_W_ACT = 2;
    localparam int FS_L4_POS = 0;
    localparam int FS_DSCP_POS = 16;
    localparam int FS_VALID_POS = 22;
    localparam int A1_QOS_ENA_POS = 0;
    localparam int A1_QOS_POS = 1;
    localparam int A1_TAG_ENA_POS = 4;
    localparam int A1_TAG_POS = 5;
    localparam int A1_DSCP_ENA_POS = 13;
    localparam int A1_DSCP_POS = 14;

    // Access-check entry words.
    localparam int AC_W_KEY = 0;
    localparam int AC_W_MASK = 1;
    localparam int AC_W_L4 = 2;
    localparam int AC_W_ACT = 3;
    localparam int AC_TAG_POS = 0;
    localparam int AC_PORTS_POS = 8;
    localparam int AC_VALID_POS = 19;
    localparam int AC_SECOND_POS = 20;
    localparam int AC_ARP_POS = 21;
    localparam int AC_L4_KEY_POS = 0;
    localparam int AC_L4_MASK_POS = 16;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] cpu_queue;
        logic single_shot;
        logic mask_mode;
        logic [10:0] port_mask;
    } action_t;

    typedef struct packed {
        logic valid;
        logic [3:0] port;
        logic [5:0] dscp;
        logic [5:0] remap_dscp;
        logic [15:0] l4_port;
        logic arp_bcast;
        logic arp_hw_eth;
        logic arp_proto_ip;
        logic arp_len_ok;
        logic arp_sender_ok;
    } frame_key_t;

    typedef struct packed {
        logic valid;
        logic [2:0] qos;
        logic [7:0] tag;
        logic dscp_ena;
        logic [5:0] dscp;
        logic hit1;
        logic [2:0] idx1;
        action_t act1;
        logic hit2;
        logic [2:0] idx2;
        action_t act2;
        logic block;
        logic copy;
        logic [2:0] copy_queue;
    } result_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } reg_req_t;

    typedef struct packed {
        logic [NUM_PORTS-1:0][31:0] port_cfg;
        logic [15:0] common_def;
        logic [FS_ENTRIES-1:0][3:0][31:0] fs_tab;
        logic [AC_ENTRIES-1:0][3:0][31:0] ac_tab;
        logic [AC_ENTRIES-1:0] fired;
        logic [31:0] rdata;
        result_t res;
    } state_t;

endpackage

// *** ingress_acl_match_logic.sv ***
// Two-stage ternary classifier: first stage sets class, tag and remark value; access
// stage runs two lookups with port, policy and common entries and default actions.
// Assumes the frame key is valid for one cycle and software programs tables between frames.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module ingress_acl_match_logic
    import acl_match_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire reg_req_t reg_in,
    output logic [31:0] rdata_out,
    input wire frame_key_t key_in,
    input wire logic cpu_ready_in,
    output result_t result_out
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    state_t q;
    state_t d;

    logic [FS_ENTRIES-1:0] m1;
    logic [AC_ENTRIES-1:0] m2a;
    logic [AC_ENTRIES-1:0] m2b;
    logic [7:0] tag_res;
    logic [NUM_PORTS-1:0] port_onehot;
    logic [31:0] pcfg;
    logic [7:0] ptag;
    action_t pdef;
    logic [3:0] win1;
    logic [3:0] win2a;
    logic [3:0] win2b;
    logic [31:0] act1_word;
    logic tag_hit;
    logic qos_hit;
    logic dscp_hit;
    logic [2:0] shot_idx;
    logic shot_hit;
    logic shot_armed;

    // Returns {hit, index} of the highest-numbered set bit.
    function automatic logic [3:0] pick_top(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (v[i])
            begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    assign port_onehot = NUM_PORTS'(11'h001 << key_in.port);
    assign pcfg = (key_in.port <= 4'(NUM_PORTS - 1)) ? q.port_cfg[key_in.port] : 32'h0000_0000;
    assign ptag = pcfg[PCFG_TAG_POS +: 8];
    assign pdef = action_t'(pcfg[PCFG_ACT_POS +: 16]);

    // ----------------------------------------------------------------
    // Per-entry ternary compare
    // ----------------------------------------------------------------
    for (genvar e = 0; e < FS_ENTRIES; e++)
    begin : g_fs
        logic [31:0] k1;
        logic [31:0] mk1;
        assign k1 = q.fs_tab[e][FS_W_KEY];
        assign mk1 = q.fs_tab[e][FS_W_MASK];
        // Cleared mask bits are don't-care, so an unprogrammed key field matches anything.
        assign m1[e] = k1[FS_VALID_POS]
            && (((key_in.l4_port ^ k1[FS_L4_POS +: 16]) & mk1[FS_L4_POS +: 16]) == 16'h0000)
            && (((key_in.dscp ^ k1[FS_DSCP_POS +: 6]) & mk1[FS_DSCP_POS +: 6]) == 6'h00);
    end

    for (genvar e = 0; e < AC_ENTRIES; e++)
    begin : g_ac
        logic [31:0] k2;
        logic [31:0] mk2;
        logic [31:0] l4w;
        logic base;
        logic arp_ok;
        assign k2 = q.ac_tab[e][AC_W_KEY];
        assign mk2 = q.ac_tab[e][AC_W_MASK];
        assign l4w = q.ac_tab[e][AC_W_L4];
        assign arp_ok = !k2[AC_ARP_POS] || (key_in.arp_bcast && key_in.arp_hw_eth
            && key_in.arp_proto_ip && key_in.arp_len_ok && key_in.arp_sender_ok);
        assign base = k2[AC_VALID_POS] && arp_ok
            && (((tag_res ^ k2[AC_TAG_POS +: 8]) & mk2[AC_TAG_POS +: 8]) == 8'h00)
            && (((port_onehot ^ k2[AC_PORTS_POS +: NUM_PORTS])
                & mk2[AC_PORTS_POS +: NUM_PORTS]) == 11'h000)
            && (((key_in.l4_port ^ l4w[AC_L4_KEY_POS +: 16])
                & l4w[AC_L4_MASK_POS +: 16]) == 16'h0000);
        assign m2a[e] = base && !k2[AC_SECOND_POS];
        assign m2b[e] = base && k2[AC_SECOND_POS];
    end

    // ----------------------------------------------------------------
    // First stage and access lookup resolution
    // ----------------------------------------------------------------
    assign win1 = pick_top({4'h0, m1});
    assign act1_word = win1[3] ? q.fs_tab[win1[1:0]][FS_W_ACT] : 32'h0000_0000;
    assign tag_hit = win1[3] && act1_word[A1_TAG_ENA_POS];
    assign qos_hit = win1[3] && act1_word[A1_QOS_ENA_POS];
    assign dscp_hit = win1[3] && act1_word[A1_DSCP_ENA_POS];

    // Resolved tag used by the access stage.
    assign tag_res = tag_hit ? act1_word[A1_TAG_POS +: 8] : ptag;

    assign win2a = pick_top(m2a);
    assign win2b = pick_top(m2b);

    // The first lookup's single-shot entry takes precedence over the second lookup's.
    always_comb
    begin
        shot_hit = 1'b0;
        shot_idx = 3'h0;
        if (win2a[3] && q.ac_tab[win2a[2:0]][AC_W_ACT][12])
        begin
            shot_hit = 1'b1;
            shot_idx = win2a[2:0];
        end
        else if (win2b[3] && q.ac_tab[win2b[2:0]][AC_W_ACT][12])
        begin
            shot_hit = 1'b1;
            shot_idx = win2b[2:0];
        end
        shot_armed = !q.fired[shot_idx];
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.rdata = 32'h0000_0000;

        // Register writes.
        if (reg_in.we)
        begin
            if (reg_in.addr <= PORT_CFG_LAST)
            begin
                d.port_cfg[reg_in.addr[3:0]] = reg_in.wdata;
            end
            else if (reg_in.addr == COMMON_DEF_ADDR)
            begin
                d.common_def = reg_in.wdata[15:0];
            end
            else if (reg_in.addr[7:4] == FS_REGION)
            begin
                d.fs_tab[reg_in.addr[3:2]][reg_in.addr[1:0]] = reg_in.wdata;
            end
            else if (reg_in.addr[7:5] == AC_REGION)
            begin
                d.ac_tab[reg_in.addr[4:2]][reg_in.addr[1:0]] = reg_in.wdata;
            end
        end

        // Register reads; data stands in the next cycle only.
        if (reg_in.re)
        begin
            if (reg_in.addr <= PORT_CFG_LAST)
            begin
                d.rdata = q.port_cfg[reg_in.addr[3:0]];
            end
            else if (reg_in.addr == COMMON_DEF_ADDR)
            begin
                d.rdata = {16'h0000, q.common_def};
            end
            else if (reg_in.addr == STATUS_ADDR)
            begin
                d.rdata = {24'h00_0000, q.fired};
            end
            else if (reg_in.addr[7:4] == FS_REGION)
            begin
                d.rdata = q.fs_tab[reg_in.addr[3:2]][reg_in.addr[1:0]];
            end
            else if (reg_in.addr[7:5] == AC_REGION)
            begin
                d.rdata = q.ac_tab[reg_in.addr[4:2]][reg_in.addr[1:0]];
            end
        end

        // Processor readiness re-arms single-shot entries; a new copy in the same cycle wins.
        if (cpu_ready_in)
        begin
            d.fired = '0;
        end

        // Frame result.
        d.res = '0;
        d.res.valid = key_in.valid;
        if (key_in.valid)
        begin
            d.res.tag = tag_res;
            d.res.qos = qos_hit ? act1_word[A1_QOS_POS +: 3] : pcfg[PCFG_QOS_POS +: 3];
            d.res.dscp_ena = dscp_hit;
            d.res.dscp = dscp_hit ? act1_word[A1_DSCP_POS +: 6] : key_in.remap_dscp;
            d.res.hit1 = win2a[3];
            d.res.idx1 = win2a[2:0];
            // An all-zero action leaves forwarding as it is.
            d.res.act1 = win2a[3] ? action_t'(q.ac_tab[win2a[2:0]][AC_W_ACT][15:0]) : pdef;
            d.res.hit2 = win2b[3];
            d.res.idx2 = win2b[2:0];
            d.res.act2 = win2b[3] ? action_t'(q.ac_tab[win2b[2:0]][AC_W_ACT][15:0])
                : action_t'(q.common_def);
            d.res.block = shot_hit;
            if (shot_hit && shot_armed)
            begin
                d.res.copy = 1'b1;
                d.res.copy_queue = q.ac_tab[shot_idx][AC_W_ACT][15:13];
                d.fired[shot_idx] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata_out = q.rdata;
    assign result_out = q.res;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    result_timing_a: assert property (key_in.valid |=> result_out.valid)
        else $error("Result did not follow frame key by one cycle.");

    first_default_a: assert property (key_in.valid && !win2a[3] ##1 1'b1 |->
        result_out.act1 == $past(pdef) && !result_out.hit1)
        else $error("First lookup miss did not take the port default action.");

    second_default_a: assert property (result_out.valid && !result_out.hit2 |->
        result_out.act2 == action_t'($past(q.common_def)))
        else $error("Second lookup miss did not take the common default action.");

    winner_order_a: assert property (result_out.valid && result_out.hit1 |->
        ($past(m2a) >> result_out.idx1) == 8'h01)
        else $error("First lookup winner is not the highest matching entry.");

    tag_start_a: assert property (key_in.valid && !tag_hit |=> result_out.tag == $past(ptag))
        else $error("Tag did not start from the port value.");

    tag_replace_a: assert property (key_in.valid && tag_hit |=>
        result_out.tag == $past(act1_word[A1_TAG_POS +: 8]))
        else $error("First-stage tag action did not replace the tag.");

    class_default_a: assert property (key_in.valid && !qos_hit |=>
        result_out.qos == $past(pcfg[PCFG_QOS_POS +: 3]))
        else $error("Class did not fall back to the port default.");

    shot_once_a: assert property (result_out.copy |-> $past(shot_armed) && q.fired != 8'h00
        ##1 !result_out.copy || $past(cpu_ready_in) || $past(shot_idx) != $past(shot_idx, 2))
        else $error("Single-shot copy repeated without processor readiness.");

    remark_pref_a: assert property (key_in.valid && dscp_hit |=>
        result_out.dscp_ena && result_out.dscp == $past(act1_word[A1_DSCP_POS +: 6]))
        else $error("First-stage remark value did not take precedence.");

    idle_result_a: assert property (!$past(key_in.valid) |-> result_out == '0)
        else $error("Result fields not cleared outside a result cycle.");

    first_index_a: assert property (key_in.valid && win2a[3] |=>
        result_out.hit1 && result_out.idx1 == $past(win2a[2:0]))
        else $error("First lookup winner index lost.");

    second_index_a: assert property (key_in.valid && win2b[3] |=>
        result_out.hit2 && result_out.idx2 == $past(win2b[2:0]))
        else $error("Second lookup winner index lost.");

    first_action_a: assert property (key_in.valid && win2a[3] |=>
        result_out.act1 == $past(q.ac_tab[win2a[2:0]][AC_W_ACT][15:0]))
        else $error("First lookup did not apply the winning action.");

    second_action_a: assert property (key_in.valid && win2b[3] |=>
        result_out.act2 == $past(q.ac_tab[win2b[2:0]][AC_W_ACT][15:0]))
        else $error("Second lookup did not apply the winning action.");

    class_override_a: assert property (key_in.valid && qos_hit |=>
        result_out.qos == $past(act1_word[A1_QOS_POS +: 3]))
        else $error("First-stage class override not applied.");

    remark_pass_a: assert property (key_in.valid && !dscp_hit |=>
        !result_out.dscp_ena && result_out.dscp == $past(key_in.remap_dscp))
        else $error("Port remark value not passed through.");

    shot_block_a: assert property (key_in.valid && shot_hit |=> result_out.block)
        else $error("Single-shot hit did not block forwarding.");

    shot_hold_a: assert property (key_in.valid && shot_hit && !shot_armed |=>
        !result_out.copy)
        else $error("Copy sent while single-shot entry was fired.");

    copy_mark_a: assert property (result_out.copy |-> q.fired[$past(shot_idx)])
        else $error("Copy did not mark the entry as fired.");

    ready_clear_a: assert property ($past(cpu_ready_in) && !result_out.copy |->
        q.fired == 8'h00)
        else $error("Processor readiness did not re-arm single-shot entries.");

    copy_queue_a: assert property (result_out.copy |-> result_out.block
        && result_out.copy_queue == $past(q.ac_tab[shot_idx][AC_W_ACT][15:13]))
        else $error("Copy queue does not follow the single-shot action.");

    default_second_hit_a: assert property (result_out.hit2 |-> result_out.valid)
        else $error("Second lookup hit reported without a result.");

    first_hit_c: cover property (result_out.valid && result_out.hit1);
    second_miss_c: cover property (result_out.valid && !result_out.hit2);
    shot_copy_c: cover property (result_out.copy ##[1:20] result_out.block && !result_out.copy);
    tag_swap_c: cover property (key_in.valid && tag_hit ##1 result_out.hit1);

endmodule

// *** frame_source.sv ***
// Behavioural stand-in for the frame parser and forwarding pipeline.
// Assumes one core clock; keys and readiness pulses launch just after a rising edge.
`timescale 1ns/1ns
module frame_source
    import acl_match_pkg::*;
(
    input wire logic sys_clk_in,
    output frame_key_t key_out,
    output logic cpu_ready_out
);
    // ----------------------------------------------------------------
    // Drivers
    // ----------------------------------------------------------------
    initial
    begin
        key_out = '0;
        cpu_ready_out = 1'b0;
    end

    // Presents one key for one cycle, then inverts every field so stale keys never produce a result.
    task automatic send(input logic [3:0] p, input logic [5:0] d, input logic [15:0] l4,
        input logic [4:0] arp);
        frame_key_t k;
        k = {1'b1, p, d, 6'h0C, l4, arp};
        @(posedge sys_clk_in);
        key_out <= k;
        @(posedge sys_clk_in);
        key_out <= ~k;
    endtask

    // One-cycle readiness pulse from the processor.
    task automatic ready_pulse;
        @(posedge sys_clk_in);
        cpu_ready_out <= 1'b1;
        @(posedge sys_clk_in);
        cpu_ready_out <= 1'b0;
    endtask
endmodule

// *** ingress_acl_match_logic_bench.sv ***
// Self-checking bench for the two-stage ingress classifier and access check.
// Assumes the design package and the frame_source model; registers use the strobe port.
`timescale 1ns/1ns
module ingress_acl_match_logic_bench
    import acl_match_pkg::*;
;
    logic sys_clk_in;
    logic rst_n_in;
    reg_req_t reg_in;
    logic [31:0] rdata_out;
    frame_key_t key_in;
    logic cpu_ready_in;
    result_t result_out;
    int err_count = 0;
    int comparisons = 0;

    // Address in the top byte, write data below it.
    localparam logic [39:0] CFG [18] = '{
        40'h03_0009_1A5A, 40'h04_0000_0133, 40'h05_0040_0600, 40'h10_0000_0456,
        40'h20_0040_0000, 40'h21_0000_FC00, 40'h22_0000_0007,
        40'h24_0047_0000, 40'h25_003F_0000, 40'h26_000A_F41B,
        40'h48_0008_00A0, 40'h49_0000_00FF, 40'h4B_0000_0A05,
        40'h54_0008_0000, 40'h55_0007_E700,
        40'h58_0018_0000, 40'h5B_0000_B000, 40'h5C_0038_0000};

    ingress_acl_match_logic i_ingress_acl_match_logic (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .reg_in(reg_in),
        .rdata_out(rdata_out),
        .key_in(key_in),
        .cpu_ready_in(cpu_ready_in),
        .result_out(result_out)
    );

    frame_source i_frame_source (
        .sys_clk_in(sys_clk_in),
        .key_out(key_in),
        .cpu_ready_out(cpu_ready_in)
    );

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_in <= {a, d, 2'b10};
        @(posedge sys_clk_in);
        reg_in.we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_in);
        reg_in <= {a, 32'h0000_0000, 2'b01};
        @(posedge sys_clk_in);
        reg_in.re <= 1'b0;
        #1;
        chk(64'(rdata_out), 64'(e));
    endtask

    // Sends one key and compares the whole registered result one cycle later.
    task automatic frm(input logic [3:0] p, input logic [5:0] d, input logic [15:0] l4,
        input logic [4:0] arp, input logic [10:0] qt, input logic [6:0] ds,
        input logic [19:0] a1, input logic [19:0] a2, input logic [4:0] cp);
        i_frame_source.send(p, d, l4, arp);
        #1;
        chk(result_out, {1'b1, qt, ds, a1, a2, cp});
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk_in);
        err_count++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst_n_in = 1'b0;
        reg_in = '0;
        repeat (20) @(posedge sys_clk_in);
        #1;
        chk(result_out, 64'h0);
        chk(64'(rdata_out), 64'h0);
        rst_n_in <= 1'b1;
        rd(8'h11, 32'h0000_0000);
        $display("test reset done");

        for (int i = 0; i < 4; i++)
            wr(CFG[i][39:32], CFG[i][31:0]);
        frm(4'h3, 6'h08, 16'h07D0, 5'h1F, 11'h25A, 7'h0C, 20'h0_0123, 20'h0_0456, 5'h00);
        $display("test defaults done");

        for (int i = 4; i < 18; i++)
            wr(CFG[i][39:32], CFG[i][31:0]);
        wr(8'h5F, 32'h0000_0011);
        frm(4'h3, 6'h07, 16'h07D0, 5'h1F, 11'h5A0, 7'h6B, 20'hD_0000, 20'hF_0011, 5'h00);
        frm(4'h5, 6'h07, 16'h0005, 5'h1F, 11'h5A0, 7'h6B, 20'hA_0A05, 20'hF_0011, 5'h00);
        frm(4'h4, 6'h08, 16'h03FF, 5'h1F, 11'h333, 7'h0C, 20'hD_0000, 20'hF_0011, 5'h00);
        frm(4'h5, 6'h08, 16'h0400, 5'h1F, 11'h600, 7'h0C, 20'h0_0800, 20'hF_0011, 5'h00);
        $display("test lookups done");

        // Each failed sanity check drops to the single-shot entry; only the first copies.
        for (int k = 0; k < 5; k++)
            frm(4'h5, 6'h08, 16'h0400, 5'(5'h1F ^ (5'h01 << k)), 11'h600, 7'h0C,
                20'h0_0800, 20'hE_B000, {1'b1, k == 0, (k == 0) ? 3'd5 : 3'd0});
        rd(8'h11, 32'h0000_0040);
        i_frame_source.ready_pulse();
        rd(8'h11, 32'h0000_0000);
        frm(4'h5, 6'h08, 16'h0400, 5'h0F, 11'h600, 7'h0C, 20'h0_0800, 20'hE_B000, 5'h1D);
        frm(4'h5, 6'h08, 16'h0400, 5'h0F, 11'h600, 7'h0C, 20'h0_0800, 20'hE_B000, 5'h10);
        $display("test single shot done");

        rd(8'h03, 32'h0009_1A5A);
        wr(8'h11, 32'hFFFF_FFFF);
        rd(8'h11, 32'h0000_0040);
        wr(8'h30, 32'hFFFF_FFFF);
        rd(8'h30, 32'h0000_0000);
        $display("test registers done");
        tally_and_finish();
    end
endmodule
